// ### design/ocs_command_interpreter.sv
// Two-wire slave command interpreter with divider, output-select and bus registers.
// How it works
// [R1] Write: address with direction 0, acknowledged command byte, then data bytes.
// [R2] Read: command written first, repeated START, address resent with direction 1.
// [R3] Command 01 in a write loads following data bytes into divider register.
// [R4] Command 01 then read returns divider register contents.
// [R5] Command 02 in a write loads next data byte into output-select register.
// [R6] Command 02 then read returns output-select register contents.
// [R7] Command 0D in a write loads next byte into bus-configuration register.
// [R8] Command 0D then read returns bus-configuration register contents.
// [R9] Write policy 0: nonvolatile store updated automatically at end of each command.
// [R10] Write policy 1: divider and select stored only by command 3F, which copies both.
// [R11] Bus-configuration writes always go to nonvolatile store, whatever the policy.
// [R12] While a store runs, every transfer request gets a not-acknowledge.
// [R13] Acknowledge control byte only on matching type code and device select bits.
// [R14] Unknown command codes change no register and no nonvolatile content.
module ocs_command_interpreter
  import ocs_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = NV_STORE_CYCLES
) (
  // Clock and synchronous active-low reset.
  input wire logic CLK,
  input wire logic RST_B,
  // Two-wire bus pins; SDA is open drain and pulled low while SDA_OE is high.
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Live register contents.
  output logic [15:0] DIVIDER_VALUE,
  output logic [7:0] OUTPUT_SELECT_VALUE,
  output logic [7:0] BUS_CONFIG_VALUE,
  // Nonvolatile store contents and activity.
  output logic [15:0] NV_DIVIDER,
  output logic [7:0] NV_OUTPUT_SELECT,
  output logic [7:0] NV_BUS_CONFIG,
  output logic NV_BUSY
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    ocs_phase_t phase;
    logic [3:0] bit_cnt;
    logic in_ack;
    logic master_ack;
    logic [7:0] shift;
    logic have_cmd;
    logic [7:0] cmd;
    logic [1:0] byte_idx;
    logic sda_oe;
    logic [15:0] divider;
    logic [7:0] out_sel;
    logic [7:0] bus_cfg;
    logic [15:0] nv_divider;
    logic [7:0] nv_out_sel;
    logic [7:0] nv_bus_cfg;
    logic pend_dm;
    logic pend_bus;
    logic [31:0] busy_cnt;
    logic nv_busy;
  } ocs_state_t;

  ocs_state_t state_reg;
  ocs_state_t state_next;

  // Byte returned for a read, chosen by the last command and the byte position.
  function automatic logic [7:0] read_byte(input ocs_state_t s, input logic [1:0] idx);
    logic [7:0] b;
    b = READ_FILL_BYTE;
    case (s.cmd)
      CMD_ACCESS_DIVIDER: begin
        if (idx == 2'h0) begin
          b = s.divider[15:8]; // R4
        end else if (idx == 2'h1) begin
          b = s.divider[7:0]; // R4
        end
      end
      CMD_ACCESS_OUTPUT_SELECT: b = (idx == 2'h0) ? s.out_sel : READ_FILL_BYTE; // R6
      CMD_ACCESS_BUS_CONFIG: b = (idx == 2'h0) ? s.bus_cfg : READ_FILL_BYTE; // R8
      default: b = READ_FILL_BYTE;
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic busy;
  logic addr_match;
  logic policy_auto;
  logic [7:0] tx_byte;

  // Edges and bus conditions are taken from the second and third flops only.
  always_comb begin
    scl_rise = state_reg.scl_s2 && !state_reg.scl_d;
    scl_fall = !state_reg.scl_s2 && state_reg.scl_d;
    start_cond = state_reg.scl_s2 && state_reg.scl_d && !state_reg.sda_s2 && state_reg.sda_d;
    stop_cond = state_reg.scl_s2 && state_reg.scl_d && state_reg.sda_s2 && !state_reg.sda_d;
    busy = state_reg.busy_cnt != 32'h0;
    policy_auto = !state_reg.bus_cfg[BUS_POLICY_BIT];
    addr_match = (state_reg.shift[CTL_TYPE_MSB:CTL_TYPE_LSB] == DEVICE_TYPE_CODE) &&
                 (state_reg.shift[CTL_SEL_MSB:CTL_SEL_LSB] ==
                  state_reg.bus_cfg[BUS_SEL_MSB:BUS_SEL_LSB]) && !busy; // R13 R12
    tx_byte = read_byte(state_reg, state_reg.byte_idx);

    state_next = state_reg;
    state_next.scl_s1 = SCL_IN;
    state_next.scl_s2 = state_reg.scl_s1;
    state_next.scl_d = state_reg.scl_s2;
    state_next.sda_s1 = SDA_IN;
    state_next.sda_s2 = state_reg.sda_s1;
    state_next.sda_d = state_reg.sda_s2;

    // The store timer counts down; the device is deaf until it expires.
    if (busy) begin
      state_next.busy_cnt = state_reg.busy_cnt - 32'h1;
    end

    if (start_cond) begin
      // A repeated START keeps the command so a read can follow it.
      state_next.phase = PH_ADDR; // R2
      state_next.bit_cnt = 4'h0;
      state_next.in_ack = 1'b0;
      state_next.sda_oe = 1'b0;
    end else if (stop_cond) begin
      // End of command: start a store for whatever is pending.
      state_next.phase = PH_IDLE;
      state_next.sda_oe = 1'b0;
      state_next.in_ack = 1'b0;
      if ((state_reg.pend_dm || state_reg.pend_bus) && !busy) begin
        if (state_reg.pend_dm) begin
          state_next.nv_divider = state_reg.divider; // R9 R10
          state_next.nv_out_sel = state_reg.out_sel; // R9 R10
        end
        if (state_reg.pend_bus) begin
          state_next.nv_bus_cfg = state_reg.bus_cfg; // R11
        end
        state_next.pend_dm = 1'b0;
        state_next.pend_bus = 1'b0;
        state_next.busy_cnt = 32'(STORE_CYCLES); // R12
      end
    end else if (state_reg.phase != PH_IDLE) begin
      if (scl_rise) begin
        if (state_reg.in_ack) begin
          state_next.master_ack = !state_reg.sda_s2;
        end else if (state_reg.bit_cnt != 4'h8) begin
          if (state_reg.phase != PH_TRANSMIT) begin
            state_next.shift = {state_reg.shift[6:0], state_reg.sda_s2};
          end
          state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
        end
      end else if (scl_fall) begin
        if (state_reg.in_ack) begin
          // Ninth clock over: release the line or drive the next read byte.
          state_next.in_ack = 1'b0;
          state_next.bit_cnt = 4'h0;
          state_next.sda_oe = 1'b0;
          if (state_reg.phase == PH_TRANSMIT) begin
            if (state_reg.master_ack) begin
              state_next.shift = tx_byte;
              state_next.sda_oe = !tx_byte[7];
            end else begin
              state_next.phase = PH_IDLE;
            end
          end
        end else if (state_reg.bit_cnt == 4'h8) begin
          // Byte complete: decide the acknowledge and act on the byte.
          state_next.in_ack = 1'b1;
          state_next.sda_oe = 1'b0;
          case (state_reg.phase)
            PH_ADDR: begin
              if (addr_match) begin
                state_next.sda_oe = 1'b1; // R13
                state_next.byte_idx = 2'h0;
                state_next.master_ack = 1'b1;
                if (state_reg.shift[CTL_RW_BIT]) begin
                  state_next.phase = PH_TRANSMIT; // R2
                end else begin
                  state_next.phase = PH_RECEIVE; // R1
                  state_next.have_cmd = 1'b0;
                end
              end else begin
                state_next.phase = PH_IDLE; // R12 R13
                state_next.in_ack = 1'b0;
              end
            end
            PH_RECEIVE: begin
              state_next.sda_oe = 1'b1; // R1
              if (!state_reg.have_cmd) begin
                state_next.cmd = state_reg.shift; // R1
                state_next.have_cmd = 1'b1;
                state_next.byte_idx = 2'h0;
                if (state_reg.shift == CMD_COMMIT_NONVOLATILE) begin
                  state_next.pend_dm = 1'b1; // R10
                end
              end else begin
                if (state_reg.byte_idx != 2'h3) begin
                  state_next.byte_idx = state_reg.byte_idx + 2'h1;
                end
                case (state_reg.cmd)
                  CMD_ACCESS_DIVIDER: begin
                    if (state_reg.byte_idx == 2'h0) begin
                      state_next.divider[15:8] = state_reg.shift; // R3
                    end else if (state_reg.byte_idx == 2'h1) begin
                      state_next.divider[7:0] = state_reg.shift; // R3
                    end
                    if (policy_auto) begin
                      state_next.pend_dm = 1'b1; // R9
                    end
                  end
                  CMD_ACCESS_OUTPUT_SELECT: begin
                    if (state_reg.byte_idx == 2'h0) begin
                      state_next.out_sel = state_reg.shift; // R5
                    end
                    if (policy_auto) begin
                      state_next.pend_dm = 1'b1; // R9
                    end
                  end
                  CMD_ACCESS_BUS_CONFIG: begin
                    if (state_reg.byte_idx == 2'h0) begin
                      state_next.bus_cfg = state_reg.shift & BUS_CONFIG_WRITE_MASK; // R7
                      state_next.pend_bus = 1'b1; // R11
                    end
                  end
                  default: state_next.cmd = state_reg.cmd; // R14
                endcase
              end
            end
            PH_TRANSMIT: begin
              // Byte sent; step to the next one while the master acknowledges.
              if (state_reg.byte_idx != 2'h3) begin
                state_next.byte_idx = state_reg.byte_idx + 2'h1;
              end
            end
            default: state_next.phase = PH_IDLE;
          endcase
        end else if (state_reg.phase == PH_TRANSMIT && state_reg.bit_cnt != 4'h0) begin
          // Next read bit goes out while the clock is low.
          state_next.shift = {state_reg.shift[6:0], 1'b0};
          state_next.sda_oe = !state_reg.shift[6]; // R4 R6 R8
        end
      end
    end
    state_next.nv_busy = state_next.busy_cnt != 32'h0; // R12
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset; line samplers start at the idle-high bus level.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_reg <= '0;
      state_reg.scl_s1 <= 1'b1;
      state_reg.scl_s2 <= 1'b1;
      state_reg.scl_d <= 1'b1;
      state_reg.sda_s1 <= 1'b1;
      state_reg.sda_s2 <= 1'b1;
      state_reg.sda_d <= 1'b1;
      state_reg.phase <= PH_IDLE;
      state_reg.divider <= DIVIDER_RESET;
      state_reg.out_sel <= OUTPUT_SELECT_RESET;
      state_reg.bus_cfg <= BUS_CONFIG_RESET;
      state_reg.nv_divider <= DIVIDER_RESET;
      state_reg.nv_out_sel <= OUTPUT_SELECT_RESET;
      state_reg.nv_bus_cfg <= BUS_CONFIG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all but the constant SDA_OUT taken from the state register
  // ----------------------------------------------------------------
  // Open-drain data: the driven level is always low.
  assign SDA_OUT = 1'b0;
  assign SDA_OE = state_reg.sda_oe;
  assign DIVIDER_VALUE = state_reg.divider;
  assign OUTPUT_SELECT_VALUE = state_reg.out_sel;
  assign BUS_CONFIG_VALUE = state_reg.bus_cfg;
  assign NV_DIVIDER = state_reg.nv_divider;
  assign NV_OUTPUT_SELECT = state_reg.nv_out_sel;
  assign NV_BUS_CONFIG = state_reg.nv_bus_cfg;
  assign NV_BUSY = state_reg.nv_busy;

endmodule

// ### shared/ocs_pkg.sv
// Constants and types shared by the oscillator command interpreter.
package ocs_pkg;

  // ----------------------------------------------------------------
  // Clock and nonvolatile store timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned NV_STORE_TIME_NS = 10000000;
  localparam int unsigned NV_STORE_CYCLES = NV_STORE_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Control byte layout
  // ----------------------------------------------------------------
  // Device-type code of the control byte; the value is arbitrary.
  localparam logic [3:0] DEVICE_TYPE_CODE = 4'h6;
  localparam int unsigned CTL_TYPE_MSB = 7;
  localparam int unsigned CTL_TYPE_LSB = 4;
  localparam int unsigned CTL_SEL_MSB = 3;
  localparam int unsigned CTL_SEL_LSB = 1;
  localparam int unsigned CTL_RW_BIT = 0;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ACCESS_DIVIDER = 8'h01;
  localparam logic [7:0] CMD_ACCESS_OUTPUT_SELECT = 8'h02;
  localparam logic [7:0] CMD_ACCESS_BUS_CONFIG = 8'h0d;
  localparam logic [7:0] CMD_COMMIT_NONVOLATILE = 8'h3f;

  // ----------------------------------------------------------------
  // Bus-configuration register fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BUS_POLICY_BIT = 3;
  localparam int unsigned BUS_SEL_MSB = 2;
  localparam int unsigned BUS_SEL_LSB = 0;
  localparam logic [7:0] BUS_CONFIG_WRITE_MASK = 8'h0f;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;
  localparam logic [7:0] OUTPUT_SELECT_RESET = 8'h00;
  localparam logic [7:0] BUS_CONFIG_RESET = 8'h00;
  localparam logic [7:0] READ_FILL_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Serial transfer phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_RECEIVE,
    PH_TRANSMIT
  } ocs_phase_t;

endpackage

// ### test/ocs_sva.sv
// Port assertions for the oscillator command interpreter.
module ocs_sva
  import ocs_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = 20
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_B,
  // Bus pins.
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  // Registers and store.
  input wire logic [15:0] DIVIDER_VALUE,
  input wire logic [7:0] OUTPUT_SELECT_VALUE,
  input wire logic [7:0] BUS_CONFIG_VALUE,
  input wire logic [15:0] NV_DIVIDER,
  input wire logic [7:0] NV_OUTPUT_SELECT,
  input wire logic [7:0] NV_BUS_CONFIG,
  input wire logic NV_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] busy_reg;
  // Counts the clocks of the running store.
  always_ff @(posedge CLK) begin
    busy_reg <= NV_BUSY ? busy_reg + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence s_oe_stands;
    SDA_OE [*8];
  endsequence
  property p_open_drain;
    SDA_OUT == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("SDA driven high");
  property p_oe_scl_low;
    $changed(SDA_OE) |-> !SCL_IN && !$past(SCL_IN);
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("SDA moved with SCL high");
  property p_oe_hold;
    $rose(SDA_OE) |-> s_oe_stands;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("SDA low too short");
  property p_busy_len;
    $fell(NV_BUSY) |-> busy_reg == 32'(STORE_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("Store length wrong");
  property p_busy_max;
    busy_reg <= 32'(STORE_CYCLES);
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("Store too long");
  property p_nack_busy;
    NV_BUSY && $past(NV_BUSY) |-> !$rose(SDA_OE);
  endproperty
  a_nack_busy: assert property (p_nack_busy) else $error("Answer while busy");
  property p_frozen;
    NV_BUSY |=> $stable({DIVIDER_VALUE, OUTPUT_SELECT_VALUE, BUS_CONFIG_VALUE});
  endproperty
  a_frozen: assert property (p_frozen) else $error("Register moved while busy");
  property p_nv_store;
    $changed({NV_DIVIDER, NV_OUTPUT_SELECT, NV_BUS_CONFIG}) |-> ##[0:4] NV_BUSY;
  endproperty
  a_nv_store: assert property (p_nv_store) else $error("Store without busy");
  property p_mask;
    ((BUS_CONFIG_VALUE | NV_BUS_CONFIG) & ~BUS_CONFIG_WRITE_MASK) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("Reserved bus bits set");
  property p_reg_scl_low;
    $changed({DIVIDER_VALUE, OUTPUT_SELECT_VALUE, BUS_CONFIG_VALUE}) |-> !SCL_IN;
  endproperty
  a_reg_scl_low: assert property (p_reg_scl_low) else $error("Load with SCL high");
endmodule

// ### test/ocs_master.sv
// Behavioural two-wire bus master driving SCL and SDA.
module ocs_master (
  // Clock and the device's pull-down.
  input wire logic clk,
  input wire logic sda_oe,
  // Bus lines as the device sees them.
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b1;
  int hold = 0;
  // Pulled-up open-drain line: low while either party pulls it.
  assign sda = drv & (sda_oe !== 1'b1);
  initial scl = 1'b1;
  // Waits some clocks; every change happens just after an edge.
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit: data set in SCL low, sampled mid SCL high; hold stretches the low phase.
  task automatic bit_io(input logic b, output logic r);
    tk(6 + hold);
    drv <= b;
    tk(6);
    scl <= 1'b1;
    tk(6);
    r = sda;
    tk(6);
    scl <= 1'b0;
  endtask
  // START or repeated START.
  task automatic start_c();
    tk(6);
    drv <= 1'b1;
    tk(6);
    scl <= 1'b1;
    tk(6);
    drv <= 1'b0;
    tk(6);
    scl <= 1'b0;
  endtask
  // STOP, leaving the bus free.
  task automatic stop_c();
    tk(6);
    drv <= 1'b0;
    tk(6);
    scl <= 1'b1;
    tk(6);
    drv <= 1'b1;
    tk(6);
  endtask
  // Sends a byte MSB first and reports the acknowledge.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Reads a byte, answering a not-acknowledge on the last one.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ### test/ocs_command_interpreter_bench.sv
// Self-checking bench for the oscillator command interpreter.
module ocs_command_interpreter_bench;
  import ocs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 1500;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, sda, sda_out, sda_oe, busy;
  logic [15:0] div, nv_div;
  logic [7:0] osel, bcfg, nv_osel, nv_bcfg;
  logic [31:0] seed = 32'hcd7bbe1d;
  int n_errors = 0;
  int comparisons = 0;
  ocs_command_interpreter #(.STORE_CYCLES(SC)) u_dut (
    .CLK(clk), .RST_B(rst_b), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .DIVIDER_VALUE(div), .OUTPUT_SELECT_VALUE(osel),
    .BUS_CONFIG_VALUE(bcfg), .NV_DIVIDER(nv_div), .NV_OUTPUT_SELECT(nv_osel),
    .NV_BUS_CONFIG(nv_bcfg), .NV_BUSY(busy));
  ocs_master u_m (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // Free-running 40 MHz clock.
  initial forever #12.5 clk = ~clk;
  // Pseudo-random step and the expected control byte.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ctl(input logic [2:0] sel, input logic rw);
    return {DEVICE_TYPE_CODE, sel, rw};
  endfunction
  // Compares one value and counts the result.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Control byte and command, bus left open.
  task automatic head(input logic [2:0] sel, input logic [7:0] cmd, output logic ok);
    logic k;
    u_m.start_c();
    u_m.wr_byte(ctl(sel, 1'b0), ok);
    u_m.wr_byte(cmd, k);
  endtask
  // Full write of n data bytes, MSB byte first.
  task automatic wr(input logic [2:0] sel, input logic [7:0] cmd, input int n,
      input logic [15:0] d, output logic ok);
    logic k;
    head(sel, cmd, ok);
    for (int i = n - 1; i >= 0; i--) u_m.wr_byte(d[8*i+:8], k);
    u_m.stop_c();
  endtask
  // Command, repeated START, then n read bytes.
  task automatic rd(input logic [2:0] sel, input logic [7:0] cmd, input int n,
      output logic [15:0] d);
    logic ok;
    logic [7:0] b;
    d = 16'h0000;
    head(sel, cmd, ok);
    u_m.start_c();
    u_m.wr_byte(ctl(sel, 1'b1), ok);
    for (int i = n - 1; i >= 0; i--) begin
      u_m.rd_byte(i == 0, b);
      d = {d[7:0], b};
    end
    u_m.stop_c();
  endtask
  // Waits, bounded, for any store to finish.
  task automatic settle();
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 5000) begin
      @(posedge clk);
      t++;
    end
    chk(16'(t >= 5000), 16'h0000);
    repeat (8) @(posedge clk);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    logic ok;
    logic [15:0] d, e;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    chk(bcfg, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      e = seed[15:0];
      u_m.hold = int'(seed[18:16]);
      wr(3'h0, CMD_ACCESS_DIVIDER, 2, e, ok);
      chk(ok, 16'h0001);
      chk(div, e);
      wr(3'h0, CMD_ACCESS_DIVIDER, 1, ~e, ok);
      chk(ok, 16'h0000);
      settle();
      chk(div, e);
      chk(nv_div, e);
      wr(3'h0, CMD_ACCESS_OUTPUT_SELECT, 1, {8'h00, seed[31:24]}, ok);
      chk(ok, 16'h0001);
      chk(osel, seed[31:24]);
      settle();
      chk(nv_osel, seed[31:24]);
      rd(3'h0, CMD_ACCESS_DIVIDER, 2, d);
      chk(d, e);
      rd(3'h0, CMD_ACCESS_OUTPUT_SELECT, 1, d);
      chk(d, seed[31:24]);
    end
    u_m.start_c();
    u_m.wr_byte(ctl(3'h0, 1'b0) ^ 8'h80, ok);
    u_m.stop_c();
    chk(ok, 16'h0000);
    wr(3'h3, CMD_ACCESS_DIVIDER, 2, ~e, ok);
    chk(ok, 16'h0000);
    wr(3'h0, 8'h55, 1, 16'h00ff, ok);
    settle();
    chk(div, e);
    chk(osel, seed[31:24]);
    chk(nv_div, e);
    wr(3'h0, CMD_ACCESS_BUS_CONFIG, 1, 16'h00fd, ok);
    settle();
    chk(bcfg, 16'h000d);
    chk(nv_bcfg, 16'h000d);
    rd(3'h5, CMD_ACCESS_BUS_CONFIG, 1, d);
    chk(d, 16'h000d);
    wr(3'h5, CMD_ACCESS_DIVIDER, 2, ~e, ok);
    settle();
    chk(div, ~e);
    chk(nv_div, e);
    wr(3'h5, CMD_COMMIT_NONVOLATILE, 0, 16'h0000, ok);
    settle();
    chk(nv_div, ~e);
    end_of_test();
  end
endmodule
bind ocs_command_interpreter ocs_sva #(.STORE_CYCLES(STORE_CYCLES)) u_sva (
  .CLK(CLK), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .DIVIDER_VALUE(DIVIDER_VALUE), .OUTPUT_SELECT_VALUE(OUTPUT_SELECT_VALUE),
  .BUS_CONFIG_VALUE(BUS_CONFIG_VALUE), .NV_DIVIDER(NV_DIVIDER),
  .NV_OUTPUT_SELECT(NV_OUTPUT_SELECT), .NV_BUS_CONFIG(NV_BUS_CONFIG), .NV_BUSY(NV_BUSY));
